/* src/dsp_cond_decode.sv */
// condition evaluation and operand decode for the signal processor sequencer
`timescale 1ns/1ps
`default_nettype none
module dsp_cond_decode
(
	input  wire logic                                 clk_sys,
	input  wire logic                                 rstn,
	input  wire logic [3:0]                           io_flag_pin,
	input  wire logic                                 alu_zero,
	input  wire logic                                 alu_neg,
	input  wire logic                                 alu_carry,
	input  wire logic                                 alu_ovf,
	input  wire logic                                 mult_ovf,
	input  wire logic                                 mult_sign,
	input  wire logic                                 shift_ovf,
	input  wire logic                                 shift_zero,
	input  wire logic                                 bit_test,
	input  wire logic                                 instr_valid,
	input  wire logic [4:0]                           instr_cond,
	input  wire logic                                 want_compute,
	input  wire logic                                 want_reg_write,
	input  wire logic                                 want_mem_xfer,
	input  wire logic [3:0]                           dreg_field,
	input  wire logic                                 dreg_is_float,
	input  wire logic [2:0]                           gen1_index_sel,
	input  wire logic [2:0]                           gen1_step_sel,
	input  wire logic [2:0]                           gen2_index_sel,
	input  wire logic [2:0]                           gen2_step_sel,
	input  wire logic [1:0]                           imm_kind,
	input  wire logic [dsp_decode_pkg::DATA_W-1:0]    imm_field,
	input  wire logic                                 branch_take,
	input  wire logic                                 pipe_advance,
	input  wire logic                                 swap_low_wr,
	input  wire logic                                 swap_high_wr,
	input  wire logic [47:0]                          swap_wdata,
	input  wire logic                                 pending_count_wr,
	input  wire logic [dsp_decode_pkg::DATA_W-1:0]    pending_count_wdata,
	input  wire logic                                 loop_push,
	input  wire logic                                 loop_pop,
	input  wire logic [dsp_decode_pkg::ADDR_W-1:0]    loop_end_addr,
	input  wire logic [4:0]                           loop_term_code,
	input  wire logic                                 loop_pass_end,
	input  wire logic                                 wait_ctl_wr,
	input  wire logic [dsp_decode_pkg::WAITCTL_W-1:0] wait_ctl_wdata,
	input  wire logic                                 bank_one_wr,
	input  wire logic                                 bank_two_wr,
	input  wire logic [dsp_decode_pkg::DATA_W-1:0]    bank_limit_wdata,
	input  wire logic                                 dm_access,
	input  wire logic [dsp_decode_pkg::DATA_W-1:0]    dm_addr,
	output logic                                      cond_pass,
	output logic                                      do_compute,
	output logic                                      do_reg_write,
	output logic                                      do_mem_xfer,
	output logic [3:0]                                dreg_num,
	output logic                                      dreg_float,
	output logic [3:0]                                gen1_index_num,
	output logic [3:0]                                gen1_step_num,
	output logic [3:0]                                gen2_index_num,
	output logic [3:0]                                gen2_step_num,
	output logic [dsp_decode_pkg::DATA_W-1:0]         imm_value,
	output logic [dsp_decode_pkg::ADDR_W-1:0]         exec_address,
	output logic [dsp_decode_pkg::ADDR_W-1:0]         decode_pointer,
	output logic [dsp_decode_pkg::ADDR_W-1:0]         fetch_pointer,
	output logic [dsp_decode_pkg::SWAP_LO_W-1:0]      bus_swap_low,
	output logic [dsp_decode_pkg::SWAP_HI_W-1:0]      bus_swap_high,
	output logic [47:0]                               bus_swap_full,
	output logic [dsp_decode_pkg::DATA_W-1:0]         pending_loop_count,
	output logic [dsp_decode_pkg::DATA_W-1:0]         active_loop_count,
	output logic [28:0]                               loop_end_top,
	output logic                                      loop_done,
	output logic [dsp_decode_pkg::WAIT_W-1:0]         dm_wait_states,
	output logic [dsp_decode_pkg::PAGE_W-1:0]         dm_page_size,
	output logic [dsp_decode_pkg::DATA_W-1:0]         data_bank_one_limit,
	output logic [dsp_decode_pkg::DATA_W-1:0]         data_bank_two_limit,
	output logic [1:0]                                dm_bank,
	output logic [dsp_decode_pkg::DATA_W-1:0]         last_data_mem_addr
);
	import dsp_decode_pkg::*;
	localparam int ENTRY_W = 29 + DATA_W;

	// two-stage synchroniser for the external flag pins
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end
		else
		begin
			pin_meta <= io_flag_pin;
			pin_sync <= pin_meta;
		end
	end

	// loop counter is spent once it reaches zero
	logic count_expired;
	assign count_expired = (active_loop_count == COUNT_RST);

	// condition decode; odd codes in the flag range are the complement of the even ones
	function automatic logic eval_cond(input logic [4:0] code);
		logic base;
		base = 1'b0;
		unique case (code & 5'h1e)
			CC_ZERO:    base = alu_zero;
			CC_NONNEG:  base = !alu_neg;
			CC_NONPOS:  base = alu_zero || alu_neg;
			CC_CARRY:   base = alu_carry;
			CC_AOVF:    base = alu_ovf;
			CC_MOVF:    base = mult_ovf;
			CC_MSIGN:   base = mult_sign;
			CC_SOVF:    base = shift_ovf;
			CC_SZERO:   base = shift_zero;
			5'h12:      base = pin_sync[0];
			5'h14:      base = pin_sync[1];
			5'h16:      base = pin_sync[2];
			5'h18:      base = pin_sync[3];
			CC_BTEST:   base = bit_test;
			CC_LCE:     base = count_expired;
			CC_FOREVER: base = 1'b0;
			default:    base = 1'b0;
		endcase
		// the six comparisons pair up as complements too: zero/nonzero, neg/nonneg, pos/nonpos
		if (code == CC_NONNEG)
			eval_cond = !alu_neg;
		else if (code == CC_NONPOS)
			eval_cond = alu_zero || alu_neg;
		else if (code == CC_NOT_LCE)
			eval_cond = !count_expired;
		else if (code == CC_TRUE)
			eval_cond = 1'b1;
		else if (code == CC_NONZERO)
			eval_cond = !alu_zero;
		else
			eval_cond = code[0] ? !base : base;
	endfunction

	// whole-instruction gating: a failed condition stops every part, a passed one lets each wanted part go
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cond_pass    <= 1'b0;
			do_compute   <= 1'b0;
			do_reg_write <= 1'b0;
			do_mem_xfer  <= 1'b0;
		end
		else
		begin
			cond_pass    <= instr_valid && eval_cond(instr_cond);
			do_compute   <= instr_valid && eval_cond(instr_cond) && want_compute;
			do_reg_write <= instr_valid && eval_cond(instr_cond) && want_reg_write;
			do_mem_xfer  <= instr_valid && eval_cond(instr_cond) && want_mem_xfer;
		end
	end

	// operand field decode into register numbers
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			dreg_num       <= 4'h0;
			dreg_float     <= 1'b0;
			gen1_index_num <= 4'h0;
			gen1_step_num  <= 4'h0;
			gen2_index_num <= GEN2_BASE;
			gen2_step_num  <= GEN2_BASE;
		end
		else if (instr_valid)
		begin
			dreg_num       <= dreg_field;
			dreg_float     <= dreg_is_float;
			gen1_index_num <= {1'b0, gen1_index_sel};
			gen1_step_num  <= {1'b0, gen1_step_sel};
			gen2_index_num <= GEN2_BASE | {1'b0, gen2_index_sel};
			gen2_step_num  <= GEN2_BASE | {1'b0, gen2_step_sel};
		end
	end

	// immediate width by field kind; relative fields add to exec address and zero-extend
	logic [ADDR_W-1:0] rel_target;
	assign rel_target = exec_address + imm_field[ADDR_W-1:0];
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			imm_value <= COUNT_RST;
		else if (instr_valid)
		begin
			unique case (imm_kind)
				IMM_ADDR24:    imm_value <= {8'h00, imm_field[ADDR_W-1:0]};
				IMM_DATA32:    imm_value <= imm_field;
				IMM_RELADDR24: imm_value <= {8'h00, rel_target};
				default:       imm_value <= imm_field;
			endcase
		end
	end

	// three-stage address pipeline; a taken branch redirects the fetch to the immediate, or to exec address plus it for relative fields
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			fetch_pointer  <= ADDR_RST;
			decode_pointer <= ADDR_RST;
			exec_address   <= ADDR_RST;
		end
		else if (pipe_advance)
		begin
			if (branch_take && imm_kind == IMM_RELADDR24)
				fetch_pointer <= rel_target;
			else if (branch_take)
				fetch_pointer <= imm_field[ADDR_W-1:0];
			else
				fetch_pointer <= fetch_pointer + 24'h000001;
			decode_pointer <= fetch_pointer;
			exec_address   <= decode_pointer;
		end
	end

	// bus exchange halves, the full view is always their join
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_swap_low  <= 16'h0000;
			bus_swap_high <= 32'h00000000;
			bus_swap_full <= 48'h000000000000;
		end
		else
		begin
			if (swap_low_wr)
				bus_swap_low <= swap_wdata[15:0];
			if (swap_high_wr)
				bus_swap_high <= swap_wdata[47:16];
			bus_swap_full <= {swap_high_wr ? swap_wdata[47:16] : bus_swap_high,
				swap_low_wr ? swap_wdata[15:0] : bus_swap_low};
		end
	end

	// loop stack: top lives in flops, outer entries are parked in the memory
	logic [SP_W-1:0]    sp;
	logic [ENTRY_W-1:0] parked;
	loop_stack_mem #(.WIDTH(ENTRY_W)) u_stack (
		.clk_sys (clk_sys),
		.wr_en   (loop_push),
		.wr_addr (sp),
		.wr_data ({loop_end_top, active_loop_count}),
		.rd_addr (sp - 3'h1),
		.rd_data (parked)
	);

	// pending count and stack pointer
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pending_loop_count <= COUNT_RST;
			sp                 <= 3'h0;
		end
		else
		begin
			if (pending_count_wr)
				pending_loop_count <= pending_count_wdata;
			if (loop_push)
				sp <= sp + 3'h1;
			else if (loop_pop && sp != 3'h0)
				sp <= sp - 3'h1;
		end
	end

	// top entry: push loads the new loop, pop restores the parked one, pass end counts down
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			loop_end_top      <= {CC_FOREVER, ADDR_RST};
			active_loop_count <= COUNT_RST;
			loop_done         <= 1'b0;
		end
		else
		begin
			loop_done <= loop_pass_end && eval_cond(loop_end_top[28:24]);
			if (loop_push)
			begin
				loop_end_top      <= {loop_term_code, loop_end_addr};
				active_loop_count <= pending_loop_count;
			end
			else if (loop_pop)
			begin
				loop_end_top      <= parked[ENTRY_W-1:DATA_W];
				active_loop_count <= parked[DATA_W-1:0];
			end
			else if (loop_pass_end && !count_expired)
				active_loop_count <= active_loop_count - 32'h00000001;
		end
	end

	// memory interface control: wait states, page size and bank limits
	logic [WAITCTL_W-1:0] wait_ctl;
	assign dm_wait_states = wait_ctl[WAIT_LSB +: WAIT_W];
	assign dm_page_size   = wait_ctl[PAGE_LSB +: PAGE_W];
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_ctl            <= WAITCTL_RST;
			data_bank_one_limit <= BANK_LIMIT_RST;
			data_bank_two_limit <= BANK_LIMIT_RST;
		end
		else
		begin
			if (wait_ctl_wr)
				wait_ctl <= wait_ctl_wdata;
			if (bank_one_wr)
				data_bank_one_limit <= bank_limit_wdata;
			if (bank_two_wr)
				data_bank_two_limit <= bank_limit_wdata;
		end
	end

	// bank pick and last-address copy on each data memory access
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			dm_bank            <= 2'h0;
			last_data_mem_addr <= COUNT_RST;
		end
		else if (dm_access)
		begin
			last_data_mem_addr <= dm_addr;
			if (dm_addr <= data_bank_one_limit)
				dm_bank <= 2'h0;
			else if (dm_addr <= data_bank_two_limit)
				dm_bank <= 2'h1;
			else
				dm_bank <= 2'h2;
		end
	end
endmodule
`default_nettype wire

/* src/dsp_decode_pkg.sv */
// shared constants for the condition and operand decode block
package dsp_decode_pkg;
	// condition and termination code numbering
	localparam logic [4:0] CC_ZERO     = 5'h00;
	localparam logic [4:0] CC_NONZERO  = 5'h01;
	localparam logic [4:0] CC_NONNEG   = 5'h02;
	localparam logic [4:0] CC_NEG      = 5'h03;
	localparam logic [4:0] CC_NONPOS   = 5'h04;
	localparam logic [4:0] CC_POS      = 5'h05;
	localparam logic [4:0] CC_CARRY    = 5'h06; // odd code after it is its complement
	localparam logic [4:0] CC_AOVF     = 5'h08;
	localparam logic [4:0] CC_MOVF     = 5'h0a;
	localparam logic [4:0] CC_MSIGN    = 5'h0c;
	localparam logic [4:0] CC_SOVF     = 5'h0e;
	localparam logic [4:0] CC_SZERO    = 5'h10;
	localparam logic [4:0] CC_PIN0     = 5'h12; // pins 0..3 at 12,14,16,18
	localparam logic [4:0] CC_BTEST    = 5'h1a;
	localparam logic [4:0] CC_LCE      = 5'h1c;
	localparam logic [4:0] CC_NOT_LCE  = 5'h1d;
	localparam logic [4:0] CC_FOREVER  = 5'h1e;
	localparam logic [4:0] CC_TRUE     = 5'h1f;

	// widths
	localparam int ADDR_W   = 24;
	localparam int DATA_W   = 32;
	localparam int SWAP_LO_W = 16;
	localparam int SWAP_HI_W = 32;
	localparam int STACK_DEPTH = 6;
	localparam int SP_W     = 3;

	// register group offsets for the second address generator
	localparam logic [3:0] GEN2_BASE = 4'h8;

	// immediate field kinds
	localparam logic [1:0] IMM_ADDR24    = 2'h0;
	localparam logic [1:0] IMM_DATA32    = 2'h1;
	localparam logic [1:0] IMM_RELADDR24 = 2'h2;

	// wait control field layout
	localparam int WAIT_LSB = 0;
	localparam int WAIT_W   = 3;
	localparam int PAGE_LSB = 3;
	localparam int PAGE_W   = 3;
	localparam int WAITCTL_W = 6;

	// values after reset
	localparam logic [WAITCTL_W-1:0] WAITCTL_RST = 6'h07;
	localparam logic [DATA_W-1:0]    BANK_LIMIT_RST = 32'hffffffff;
	localparam logic [ADDR_W-1:0]    ADDR_RST = 24'h000000;
	localparam logic [DATA_W-1:0]    COUNT_RST = 32'h00000000;
endpackage

/* src/loop_stack_mem.sv */
// small memory holding the saved outer loop entries
`timescale 1ns/1ps
`default_nettype none
module loop_stack_mem
	import dsp_decode_pkg::*;
#(
	parameter int WIDTH = 61
)
(
	input  wire logic             clk_sys,
	input  wire logic             wr_en,
	input  wire logic [SP_W-1:0]  wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [SP_W-1:0]  rd_addr,
	output var  logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [STACK_DEPTH];

	// write port
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read, one cycle behind the address
	always_ff @(posedge clk_sys)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

/* testbench/dsp_cond_chk.sv */
// concurrent checks on the condition and operand decode ports
`timescale 1ns/1ps
`default_nettype none
module dsp_cond_chk
	import dsp_decode_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        instr_valid,
	input wire logic [4:0]  instr_cond,
	input wire logic        want_compute,
	input wire logic        alu_zero,
	input wire logic        alu_neg,
	input wire logic        alu_carry,
	input wire logic [2:0]  gen1_index_sel,
	input wire logic [2:0]  gen2_step_sel,
	input wire logic        pipe_advance,
	input wire logic        dm_access,
	input wire logic [31:0] dm_addr,
	input wire logic        cond_pass,
	input wire logic        do_compute,
	input wire logic        do_reg_write,
	input wire logic        do_mem_xfer,
	input wire logic [3:0]  gen1_index_num,
	input wire logic [3:0]  gen2_step_num,
	input wire logic [23:0] exec_address,
	input wire logic [23:0] decode_pointer,
	input wire logic [23:0] fetch_pointer,
	input wire logic [15:0] bus_swap_low,
	input wire logic [31:0] bus_swap_high,
	input wire logic [47:0] bus_swap_full,
	input wire logic [31:0] active_loop_count,
	input wire logic [31:0] last_data_mem_addr
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_FALSE_GATES: assert property (!cond_pass |-> !(do_compute || do_reg_write || do_mem_xfer))
		else $error("part of a failed instruction ran");
	AST_TRUE_RUNS: assert property (instr_valid && instr_cond == CC_TRUE && want_compute
		|=> cond_pass && do_compute) else $error("true code did not execute");
	AST_ZERO_COND: assert property (instr_valid && instr_cond == CC_ZERO
		|=> cond_pass == $past(alu_zero)) else $error("zero condition wrong");
	AST_CARRY_NOT: assert property (instr_valid && instr_cond == 5'h07
		|=> cond_pass != $past(alu_carry)) else $error("negated carry not complement");
	AST_NEG_COND: assert property (instr_valid && instr_cond == CC_NEG
		|=> cond_pass == $past(alu_neg)) else $error("negative condition wrong");
	AST_NOT_LCE: assert property (instr_valid && instr_cond == CC_NOT_LCE
		|=> cond_pass == ($past(active_loop_count) != 32'h0)) else $error("count condition wrong");
	AST_GEN1_SEL: assert property (instr_valid
		|=> gen1_index_num == {1'b0, $past(gen1_index_sel)}) else $error("first index select wrong");
	AST_GEN2_SEL: assert property (instr_valid
		|=> gen2_step_num == {1'b1, $past(gen2_step_sel)}) else $error("second step select wrong");
	AST_SWAP_JOIN: assert property (bus_swap_full == {bus_swap_high, bus_swap_low})
		else $error("full exchange not joined");
	AST_PIPE_SHIFT: assert property (pipe_advance |=> decode_pointer == $past(fetch_pointer)
		&& exec_address == $past(decode_pointer)) else $error("pipeline addresses did not shift");
	AST_DM_COPY: assert property (dm_access
		|=> last_data_mem_addr == $past(dm_addr)) else $error("data address copy stale");
endmodule
bind dsp_cond_decode dsp_cond_chk chk_inst (.*);
`default_nettype wire

/* testbench/prog_mem_model.sv */
// program memory model returning the instruction word at the fetch address
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
	input  wire logic [23:0] fetch_pointer,
	output var  logic [4:0]  instr_cond,
	output var  logic        want_compute,
	output var  logic        want_reg_write,
	output var  logic        want_mem_xfer
);
	// contents follow the address so every code comes up in turn and the bench can predict it
	always_comb
	begin
		instr_cond = fetch_pointer[4:0];
		{want_compute, want_reg_write, want_mem_xfer} = fetch_pointer[5:3] ^ fetch_pointer[2:0];
	end
endmodule
`default_nettype wire

/* testbench/tb_dsp_condition_and_operand_decode.sv */
// self-checking bench for the condition and operand decode block
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_condition_and_operand_decode;
	import dsp_decode_pkg::*;
	logic clk_sys, rstn, instr_valid, dreg_is_float, branch_take, pipe_advance;
	logic alu_zero, alu_neg, alu_carry, alu_ovf, mult_ovf, mult_sign, shift_ovf, shift_zero;
	logic bit_test, want_compute, want_reg_write, want_mem_xfer, swap_low_wr, swap_high_wr;
	logic pending_count_wr, loop_push, loop_pop, loop_pass_end, wait_ctl_wr, bank_one_wr;
	logic bank_two_wr, dm_access, cond_pass, do_compute, do_reg_write, do_mem_xfer;
	logic dreg_float, loop_done;
	logic [3:0]  io_flag_pin, dreg_field, dreg_num, gen1_index_num, gen1_step_num;
	logic [3:0]  gen2_index_num, gen2_step_num;
	logic [2:0]  gen1_index_sel, gen1_step_sel, gen2_index_sel, gen2_step_sel;
	logic [2:0]  dm_wait_states, dm_page_size;
	logic [1:0]  imm_kind, dm_bank;
	logic [4:0]  instr_cond, loop_term_code;
	logic [5:0]  wait_ctl_wdata;
	logic [8:0]  fl;
	logic [15:0] bus_swap_low;
	logic [23:0] loop_end_addr, exec_address, decode_pointer, fetch_pointer, f, d, e;
	logic [28:0] loop_end_top;
	logic [31:0] imm_field, pending_count_wdata, bank_limit_wdata, dm_addr, imm_value;
	logic [31:0] bus_swap_high, pending_loop_count, active_loop_count, rs;
	logic [31:0] data_bank_one_limit, data_bank_two_limit, last_data_mem_addr;
	logic [47:0] swap_wdata, bus_swap_full;
	logic [31:0] da [4] = '{32'h00001000, 32'h00001001, 32'h00008001, 32'h00000000};
	logic [1:0]  db [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	int          n_mismatch, checks_done;

	assign {bit_test, shift_zero, shift_ovf, mult_sign, mult_ovf, alu_ovf, alu_carry, alu_neg,
		alu_zero} = fl;

	dsp_cond_decode dsp_cond_decode_inst (.*);
	prog_mem_model prog_mem_model_inst (.*);

	// free-running system clock, 20 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// shift register steps 32 times so every bit of a draw is fresh
	function automatic logic [31:0] nxt(input logic [31:0] s);
		for (int k = 0; k < 32; k++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction

	// expected condition: pairs above code 5 are base then complement
	function automatic logic cexp(input logic [4:0] c, input logic [8:0] g,
		input logic [3:0] p, input logic z);
		logic [15:0] base;
		base = {1'b0, z, g[8], p, g[7:2], 3'b000};
		case (c)
			5'h00: return g[0];
			5'h01: return !g[0];
			5'h02: return !g[1];
			5'h03: return g[1];
			5'h04: return g[0] | g[1];
			5'h05: return !(g[0] | g[1]);
			default: return base[c[4:1]] ^ c[0];
		endcase
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// 32 back to back instructions walking the codes, flags and fields random
	task automatic run_half(input logic z);
		logic [4:0]  c;
		logic [2:0]  w;
		logic        p;
		logic [31:0] ie;
		io_flag_pin = rs[3:0];
		repeat (3) @(negedge clk_sys); // pins pass two sync stages first
		for (int i = 0; i < 32; i++)
		begin
			c = f[4:0];
			w = f[5:3] ^ f[2:0];
			rs = nxt(rs);
			fl = rs[8:0];
			{dreg_field, dreg_is_float} = rs[13:9];
			{gen1_index_sel, gen1_step_sel, gen2_index_sel, gen2_step_sel} = rs[25:14];
			imm_kind = (rs[27:26] == 2'h3) ? IMM_RELADDR24 : rs[27:26];
			imm_field = nxt(rs);
			ie = {8'h00, imm_field[23:0] + ((imm_kind == IMM_RELADDR24) ? e : 24'h0)};
			if (imm_kind == IMM_DATA32)
				ie = imm_field;
			branch_take = (i == 31); // last instruction of each half jumps to its target
			instr_valid = 1'b1;
			pipe_advance = 1'b1;
			@(negedge clk_sys);
			p = cexp(c, fl, io_flag_pin, z);
			chk(cond_pass, p);
			chk({do_compute, do_reg_write, do_mem_xfer}, {3{p}} & w);
			chk({dreg_num, dreg_float}, {dreg_field, dreg_is_float});
			chk({gen1_index_num, gen1_step_num}, {1'b0, gen1_index_sel, 1'b0, gen1_step_sel});
			chk({gen2_index_num, gen2_step_num}, {1'b1, gen2_index_sel, 1'b1, gen2_step_sel});
			chk(imm_value, ie);
			e = d;
			d = f;
			f = branch_take ? ie[23:0] : f + 24'h1;
			chk({fetch_pointer, decode_pointer}, {f, d});
			chk(exec_address, e);
		end
		instr_valid = 1'b0;
		pipe_advance = 1'b0;
		branch_take = 1'b0;
	endtask

	// watchdog; the sequence needs only about a hundred cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		close_out();
	end

	// main sequence
	initial
	begin
		{rstn, io_flag_pin, fl, instr_valid, dreg_field, dreg_is_float, branch_take} = '0;
		{gen1_index_sel, gen1_step_sel, gen2_index_sel, gen2_step_sel, imm_kind} = '0;
		{imm_field, pipe_advance, swap_low_wr, swap_high_wr, swap_wdata} = '0;
		{pending_count_wr, pending_count_wdata, loop_push, loop_pop, loop_end_addr} = '0;
		{loop_term_code, loop_pass_end, wait_ctl_wr, wait_ctl_wdata, bank_one_wr} = '0;
		{bank_two_wr, bank_limit_wdata, dm_access, dm_addr, f, d, e} = '0;
		n_mismatch = 0;
		checks_done = 0;
		rs = 32'h0000004a;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		chk({dm_page_size, dm_wait_states}, WAITCTL_RST);
		chk({data_bank_one_limit, data_bank_two_limit}, {2{BANK_LIMIT_RST}});
		chk(exec_address, ADDR_RST);
		run_half(1'b1);
		// counted loop loaded with a count of two, count-done termination on the third pass end
		pending_count_wr = 1'b1;
		pending_count_wdata = 32'h00000002;
		@(negedge clk_sys);
		pending_count_wr = 1'b0;
		chk(pending_loop_count, 32'h2);
		loop_push = 1'b1;
		loop_end_addr = rs[23:0];
		loop_term_code = CC_LCE;
		@(negedge clk_sys);
		loop_push = 1'b0;
		chk(active_loop_count, 32'h2);
		chk(loop_end_top, {CC_LCE, rs[23:0]});
		run_half(1'b0);
		for (int i = 0; i < 3; i++)
		begin
			loop_pass_end = 1'b1;
			@(negedge clk_sys);
			chk({active_loop_count, loop_done}, {(i < 2) ? 32'(1 - i) : 32'h0, i == 2});
		end
		// pop, then a forever loop at count zero never finishes
		loop_pass_end = 1'b0;
		loop_pop = 1'b1;
		pending_count_wr = 1'b1;
		pending_count_wdata = 32'h0;
		@(negedge clk_sys);
		{loop_pop, pending_count_wr} = '0;
		chk({loop_end_top, active_loop_count}, {CC_FOREVER, ADDR_RST, COUNT_RST});
		@(negedge clk_sys);
		loop_push = 1'b1;
		loop_term_code = CC_FOREVER;
		@(negedge clk_sys);
		loop_push = 1'b0;
		loop_pass_end = 1'b1;
		@(negedge clk_sys);
		loop_pass_end = 1'b0;
		chk({loop_end_top[28:24], loop_done}, {CC_FOREVER, 1'b0});
		// exchange halves written apart, then read as one
		swap_low_wr = 1'b1;
		swap_wdata = {rs, rs[15:0]};
		@(negedge clk_sys);
		swap_low_wr = 1'b0;
		swap_high_wr = 1'b1;
		swap_wdata = ~swap_wdata;
		@(negedge clk_sys);
		swap_high_wr = 1'b0;
		chk(bus_swap_full, {~rs, rs[15:0]});
		// memory interface: wait control, limits, then boundary addresses
		{wait_ctl_wr, bank_one_wr, wait_ctl_wdata, bank_limit_wdata} = {2'b11, 6'h2b, 32'h1000};
		@(negedge clk_sys);
		{wait_ctl_wr, bank_one_wr, bank_two_wr, bank_limit_wdata} = {3'b001, 32'h8000};
		@(negedge clk_sys);
		bank_two_wr = 1'b0;
		chk({dm_page_size, dm_wait_states}, 6'h2b);
		chk({data_bank_one_limit, data_bank_two_limit}, {32'h1000, 32'h8000});
		for (int i = 0; i < 4; i++)
		begin
			dm_access = 1'b1;
			dm_addr = da[i];
			@(negedge clk_sys);
			chk(dm_bank, db[i]);
			chk(last_data_mem_addr, da[i]);
		end
		dm_access = 1'b0;
		close_out();
	end
endmodule
`default_nettype wire
